// >>> core/asr_baud_gen.sv
// Sample tick generator at sixteen times the bit rate.
// Assumes an asynchronous active-low reset and a level run enable.
`timescale 1ns/1ns
`include "asr_defines.svh"
module asr_baud_gen
   import asr_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic [7:0] divisor,
   input wire logic high_speed,
   // Sample tick
   output logic sample_tick
);
   logic [7:0] div_cnt_r;
   logic [1:0] pre_cnt_r;
   logic base_tick;

   assign base_tick = (div_cnt_r == 8'h00);

   // Divisor counter; held loaded with the divisor while stopped so the first bit is aligned
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_r <= 8'h00;
      end else if (!run || base_tick) begin
         div_cnt_r <= divisor; // R17
      end else begin
         div_cnt_r <= div_cnt_r - 8'h01;
      end
   end

   // Low-speed base clock is x64, so divide it by four to reach x16
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_r <= 2'h0;
         sample_tick <= 1'b0;
      end else if (!run) begin
         pre_cnt_r <= 2'h0;
         sample_tick <= 1'b0;
      end else begin
         if (base_tick) begin
            pre_cnt_r <= pre_cnt_r + 2'h1;
         end
         sample_tick <= base_tick && (high_speed || pre_cnt_r == `ASR_PRESCALE_LAST); // R1 R17
      end
   end

   chk_tick_low_speed: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sample_tick && run && !high_speed && $past(!high_speed) |=> !sample_tick [*3]) // R17
      else $error("low speed sample ticks closer than four base ticks");
endmodule

// >>> core/asr_defines.svh
// Constants of the serial receiver: register indices, bit positions,
// reset values and oversampling counts.
// Assumes inclusion by bare name from the design files.
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index
`define ASR_IDX_INT_CTRL 8'h0B
`define ASR_IDX_PERIPH_FLAGS 8'h0C
`define ASR_IDX_RX_STAT_CTRL 8'h18
`define ASR_IDX_TX_BUF 8'h19
`define ASR_IDX_RX_FIFO 8'h1A
`define ASR_IDX_PERIPH_EN 8'h8C
`define ASR_IDX_TX_STAT_CTRL 8'h98
`define ASR_IDX_BAUD_DIV 8'h99

// Reset values
`define ASR_RST_ZERO 8'h00
`define ASR_RST_TX_STAT_CTRL 8'h02

// Bit positions
`define ASR_BIT_GLOBAL_IRQ_EN 7
`define ASR_BIT_PERIPH_IRQ_GATE 6
`define ASR_BIT_RX_READY 5
`define ASR_BIT_SERIAL_PORT_EN 7
`define ASR_BIT_NINE_BIT_RX 6
`define ASR_BIT_CONT_RX_EN 4
`define ASR_BIT_FRAMING_ERR 2
`define ASR_BIT_OVERRUN_ERR 1
`define ASR_BIT_SYNC_MODE 4
`define ASR_BIT_HIGH_SPEED 2
`define ASR_BIT_TX_EMPTY 1

// Writable bit masks
`define ASR_MASK_PERIPH_FLAGS 8'hDF
`define ASR_MASK_RX_CTRL 8'hF0
`define ASR_MASK_TX_STAT_CTRL 8'hF5

// Oversampling: sixteen samples per bit, vote on samples 7, 8 and 9
`define ASR_OVS_FIRST_VOTE 4'h7
`define ASR_OVS_MID_VOTE 4'h8
`define ASR_OVS_DECIDE 4'h9
`define ASR_OVS_LAST 4'hF
`define ASR_PRESCALE_LAST 2'h3
`define ASR_LAST_BIT_8 4'h7
`define ASR_LAST_BIT_9 4'h8
`define ASR_FIFO_FULL 2'h2

`endif

// >>> core/asr_pkg.sv
// Types of the serial receiver.
// Assumes the constants header is compiled alongside.
package asr_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_START = 4'h2,
      ST_DATA = 4'h4,
      ST_STOP = 4'h8
   } asr_state_type;
endpackage

// >>> core/asr_receiver.sv
// Asynchronous serial receiver with AHB-Lite register slave.
// Assumes rx_pin is synchronous to clk_sys and idles high.
//
// Operation
// R1: Sample receive pin at sixteen times bit rate
// R2: Accept frames only with continuous receive enabled
// R3: Move word into FIFO after stop bit
// R4: Word in FIFO sets receive ready flag
// R5: Ready flag read-only, clears when FIFO empty
// R6: Two-word FIFO, read in arrival order
// R7: Full FIFO at stop bit sets overrun, drops
// R8: Overrun cleared only by toggling receive enable
// R9: Overrun blocks all further FIFO transfers
// R10: Stop bit low sets framing error
// R11: Framing and ninth bit follow FIFO head
// R12: Software reads status before the FIFO
// R13: Software selects async mode and enables port
// R14: Software selects nine-bit mode before enabling
// R15: Software sets global and peripheral interrupt enables
// R16: Frame is start, 8/9 data LSB first, stop
// R17: Baud tick x16 or x64 from divisor
// R18: No hardware parity
// R19: Start on falling edge, vote near centre
// R20: Disabling reception flushes state and errors
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "asr_defines.svh"
module asr_receiver
   import asr_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Serial line
   input wire logic rx_pin,
   // Interrupt request
   output logic rx_irq_r
);
   logic rst_sync1_r;
   logic rst_n;
   logic [7:0] int_ctrl_r;
   logic [7:0] periph_flags_r;
   logic [7:0] rx_ctrl_r;
   logic [7:0] tx_buf_r;
   logic [7:0] periph_en_r;
   logic [7:0] tx_stat_ctrl_r;
   logic [7:0] baud_div_r;
   logic overrun_r;
   logic wr_pend_r;
   logic [7:0] wr_idx_r;
   logic rx_on;
   logic sample_tick;
   logic [9:0] fifo_head;
   logic [1:0] fifo_count;
   logic fifo_push;
   logic fifo_pop;
   logic rx_ready;
   logic addr_take;
   logic [7:0] addr_idx;
   logic [7:0] rd_val;
   asr_state_type state_r;
   logic [3:0] ovs_cnt_r;
   logic [3:0] bit_idx_r;
   logic [8:0] shift_r;
   logic vote7_r;
   logic vote8_r;
   logic rx_prev_r;
   logic vote;
   logic word_done;
   logic stop_bit;
   logic [3:0] last_bit;
   logic [9:0] word_packed;

   // Reset release through two flops
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_sync1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_sync1_r <= 1'b1;
         rst_n <= rst_sync1_r;
      end
   end

   // Receiver runs only in async mode with port and continuous receive enabled
   assign rx_on = rx_ctrl_r[`ASR_BIT_SERIAL_PORT_EN] && rx_ctrl_r[`ASR_BIT_CONT_RX_EN]
      && !tx_stat_ctrl_r[`ASR_BIT_SYNC_MODE]; // R2 R13
   assign rx_ready = (fifo_count != 2'h0); // R4 R5
   assign last_bit = rx_ctrl_r[`ASR_BIT_NINE_BIT_RX] ? `ASR_LAST_BIT_9 : `ASR_LAST_BIT_8; // R14 R16

   // Majority of samples 7, 8 and 9 of each bit
   assign vote = (vote7_r && vote8_r) || (vote7_r && rx_pin) || (vote8_r && rx_pin); // R19
   assign word_done = sample_tick && state_r == ST_STOP && ovs_cnt_r == `ASR_OVS_DECIDE;
   assign stop_bit = vote;
   // Nine bits arrive into the top of the shifter; eight sit one place higher
   assign word_packed = rx_ctrl_r[`ASR_BIT_NINE_BIT_RX] ? {!stop_bit, shift_r}
      : {!stop_bit, 1'b0, shift_r[8:1]}; // R10 R11 R18
   assign fifo_push = word_done && !overrun_r && fifo_count != `ASR_FIFO_FULL; // R3 R9

   asr_baud_gen u_baud_gen (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .run(rx_on),
      .divisor(baud_div_r),
      .high_speed(tx_stat_ctrl_r[`ASR_BIT_HIGH_SPEED]),
      .sample_tick(sample_tick)
   );

   asr_rx_fifo u_rx_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .flush(!rx_on),
      .push(fifo_push),
      .push_data(word_packed),
      .pop(fifo_pop),
      .head(fifo_head),
      .count(fifo_count)
   );

   // Previous line level for start edge detection
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_prev_r <= 1'b1;
      end else if (sample_tick) begin
         rx_prev_r <= rx_pin;
      end
   end

   // Frame sequencer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         ovs_cnt_r <= 4'h0;
         bit_idx_r <= 4'h0;
      end else if (!rx_on) begin
         state_r <= ST_IDLE; // R2 R20
         ovs_cnt_r <= 4'h0;
         bit_idx_r <= 4'h0;
      end else if (sample_tick) begin
         ovs_cnt_r <= ovs_cnt_r + 4'h1; // R1
         case (state_r)
            ST_IDLE: begin
               ovs_cnt_r <= 4'h1;
               if (rx_prev_r && !rx_pin) begin
                  state_r <= ST_START; // R19
               end else begin
                  ovs_cnt_r <= 4'h0;
               end
            end
            ST_START: begin
               if (ovs_cnt_r == `ASR_OVS_DECIDE && vote) begin
                  state_r <= ST_IDLE;
                  ovs_cnt_r <= 4'h0;
               end else if (ovs_cnt_r == `ASR_OVS_LAST) begin
                  state_r <= ST_DATA;
                  bit_idx_r <= 4'h0;
               end
            end
            ST_DATA: begin
               if (ovs_cnt_r == `ASR_OVS_LAST) begin
                  if (bit_idx_r == last_bit) begin
                     state_r <= ST_STOP; // R16
                  end else begin
                     bit_idx_r <= bit_idx_r + 4'h1;
                  end
               end
            end
            ST_STOP: begin
               if (ovs_cnt_r == `ASR_OVS_DECIDE) begin
                  state_r <= ST_IDLE; // R3
                  ovs_cnt_r <= 4'h0;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Vote samples and data shifter, least significant bit first
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         vote7_r <= 1'b1;
         vote8_r <= 1'b1;
         shift_r <= 9'h000;
      end else if (sample_tick) begin
         if (ovs_cnt_r == `ASR_OVS_FIRST_VOTE) begin
            vote7_r <= rx_pin;
         end
         if (ovs_cnt_r == `ASR_OVS_MID_VOTE) begin
            vote8_r <= rx_pin;
         end
         if (state_r == ST_DATA && ovs_cnt_r == `ASR_OVS_DECIDE) begin
            shift_r <= {vote, shift_r[8:1]}; // R16
         end
      end
   end

   // Overrun is sticky until reception is switched off
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         overrun_r <= 1'b0;
      end else if (!rx_on) begin
         overrun_r <= 1'b0; // R8 R20
      end else if (word_done && fifo_count == `ASR_FIFO_FULL) begin
         overrun_r <= 1'b1; // R7
      end
   end

   // Bus address phase
   assign addr_take = hsel && htrans[1] && hready;
   assign addr_idx = haddr[9:2];
   // Reading the FIFO advances status bits to the next word
   assign fifo_pop = addr_take && !hwrite && addr_idx == `ASR_IDX_RX_FIFO; // R11 R12

   always_comb begin
      rd_val = 8'h00;
      case (addr_idx)
         `ASR_IDX_INT_CTRL: rd_val = int_ctrl_r;
         `ASR_IDX_PERIPH_FLAGS: rd_val = {periph_flags_r[7:6], rx_ready,
            periph_flags_r[4:0]}; // R4
         `ASR_IDX_RX_STAT_CTRL: rd_val = {rx_ctrl_r[7:4], 1'b0,
            fifo_head[9] && rx_ready, overrun_r, fifo_head[8] && rx_ready}; // R10 R11
         `ASR_IDX_TX_BUF: rd_val = tx_buf_r;
         `ASR_IDX_RX_FIFO: rd_val = fifo_head[7:0];
         `ASR_IDX_PERIPH_EN: rd_val = periph_en_r;
         `ASR_IDX_TX_STAT_CTRL: rd_val = {tx_stat_ctrl_r[7:2], 1'b1, tx_stat_ctrl_r[0]};
         `ASR_IDX_BAUD_DIV: rd_val = baud_div_r;
         default: rd_val = 8'h00;
      endcase
   end

   // Zero-wait slave: read data registered at the address phase edge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_idx_r <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= addr_take && hwrite;
         if (addr_take) begin
            wr_idx_r <= addr_idx;
         end
         if (addr_take && !hwrite) begin
            hrdata <= {24'h00_0000, rd_val};
         end
      end
   end

   // Register writes in the data phase; ready flag bit is not writable
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         int_ctrl_r <= `ASR_RST_ZERO;
         periph_flags_r <= `ASR_RST_ZERO;
         rx_ctrl_r <= `ASR_RST_ZERO;
         tx_buf_r <= `ASR_RST_ZERO;
         periph_en_r <= `ASR_RST_ZERO;
         tx_stat_ctrl_r <= `ASR_RST_TX_STAT_CTRL;
         baud_div_r <= `ASR_RST_ZERO;
      end else if (wr_pend_r) begin
         case (wr_idx_r)
            `ASR_IDX_INT_CTRL: int_ctrl_r <= hwdata[7:0];
            `ASR_IDX_PERIPH_FLAGS: periph_flags_r <= hwdata[7:0] & `ASR_MASK_PERIPH_FLAGS; // R5
            `ASR_IDX_RX_STAT_CTRL: rx_ctrl_r <= hwdata[7:0] & `ASR_MASK_RX_CTRL;
            `ASR_IDX_TX_BUF: tx_buf_r <= hwdata[7:0];
            `ASR_IDX_PERIPH_EN: periph_en_r <= hwdata[7:0];
            `ASR_IDX_TX_STAT_CTRL: tx_stat_ctrl_r <= (hwdata[7:0] & `ASR_MASK_TX_STAT_CTRL)
               | `ASR_RST_TX_STAT_CTRL;
            `ASR_IDX_BAUD_DIV: baud_div_r <= hwdata[7:0];
            default: begin
            end
         endcase
      end
   end

   // Interrupt request needs flag, enable, peripheral gate and global enable
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_irq_r <= 1'b0;
      end else begin
         rx_irq_r <= rx_ready && periph_en_r[`ASR_BIT_RX_READY]
            && int_ctrl_r[`ASR_BIT_GLOBAL_IRQ_EN] && int_ctrl_r[`ASR_BIT_PERIPH_IRQ_GATE]; // R4 R15
      end
   end

   chk_push_sets_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fifo_push && rx_on |=> rx_ready) // R4
      else $error("ready flag not set after word stored");

   chk_ready_until_empty: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_ready && !fifo_pop && rx_on |=> rx_ready) // R5
      else $error("ready flag dropped while words remain");

   chk_overrun_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
      word_done && rx_on && fifo_count == `ASR_FIFO_FULL && !fifo_pop
      |=> overrun_r && fifo_count == `ASR_FIFO_FULL) // R7
      else $error("overrun not flagged on full buffer");

   chk_overrun_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
      overrun_r && rx_on |=> overrun_r) // R8
      else $error("overrun cleared while reception enabled");

   chk_overrun_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
      overrun_r |=> fifo_count <= $past(fifo_count)) // R9
      else $error("buffer grew while overrun set");

   chk_framing_stored: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fifo_push |-> word_packed[9]
      == ((2'(vote7_r) + 2'(vote8_r) + 2'(rx_pin)) < 2'h2)) // R10
      else $error("framing bit disagrees with stop sample majority");

   chk_disable_flushes: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !rx_on |=> state_r == ST_IDLE && !overrun_r && fifo_count == 2'h0) // R2 R20
      else $error("receive state survives disable");

   chk_start_on_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_r == ST_START && $past(state_r) == ST_IDLE |-> $past(rx_pin) == 1'b0) // R19
      else $error("start entered without low line");

   chk_bit_advance: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_on && sample_tick && state_r == ST_DATA && ovs_cnt_r == `ASR_OVS_LAST
      && bit_idx_r != last_bit |=> bit_idx_r == $past(bit_idx_r) + 4'h1) // R1
      else $error("bit index did not advance after sixteen samples");
endmodule

// >>> core/asr_rx_fifo.sv
// Two-word receive buffer carrying framing error and ninth bit per word.
// Assumes the caller never pushes while it is full.
`timescale 1ns/1ns
`include "asr_defines.svh"
module asr_rx_fifo
   import asr_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Write side
   input wire logic flush,
   input wire logic push,
   input wire logic [9:0] push_data,
   // Read side
   input wire logic pop,
   output logic [9:0] head,
   output logic [1:0] count
);
   logic [9:0] slot0_r;
   logic [9:0] slot1_r;

   assign head = slot0_r;

   // Slot 0 is always the oldest word, so reads come out in arrival order
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         slot0_r <= 10'h000;
         slot1_r <= 10'h000;
         count <= 2'h0;
      end else if (flush) begin
         count <= 2'h0;
      end else if (pop && count != 2'h0) begin
         if (count == `ASR_FIFO_FULL) begin
            slot0_r <= slot1_r; // R6
            if (push) begin
               slot1_r <= push_data;
            end else begin
               count <= 2'h1;
            end
         end else if (push) begin
            slot0_r <= push_data;
         end else begin
            count <= 2'h0;
         end
      end else if (push && count == 2'h0) begin
         slot0_r <= push_data;
         count <= 2'h1;
      end else if (push && count == 2'h1) begin
         slot1_r <= push_data; // R6
         count <= `ASR_FIFO_FULL;
      end
   end

   chk_fifo_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pop && !push && !flush && count == `ASR_FIFO_FULL |=> head == $past(slot1_r)) // R6
      else $error("second word not presented after first was read");
endmodule

// >>> verif/asr_receiver_tb_top.sv
// Self-checking bench for the serial receiver: AHB-Lite master plus line model.
// Assumes a single slave, so hreadyout is fed back as hready.
`timescale 1ns/1ns
`include "asr_defines.svh"
module asr_receiver_tb_top;
   logic clk_sys, nrst, hsel, hwrite, hreadyout, hresp, rx_pin, rx_irq_r;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] b [3];
   logic [7:0] b0;
   logic [7:0] regs [9];
   int error_cnt, checked, cycles;

   asr_receiver u_asr_receiver (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_pin(rx_pin),
      .rx_irq_r(rx_irq_r));
   asr_tx_model u_asr_tx_model (.clk_sys(clk_sys), .rx_pin(rx_pin));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic give_verdict();
      $display("Errors: %0d, checks: %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Whole run needs well under this many cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         error_cnt++;
         give_verdict();
      end
   end

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Single word transfer; waits on hready in both phases, data taken at the second edge
   task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
      checked++;
      if (hresp !== 1'b0) begin
         error_cnt++;
         $display("MISMATCH hresp expected 0 seen %b", hresp);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus_xfer(1'b1, idx, {24'h0, d});
   endtask

   task automatic rdchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
      bus_xfer(1'b0, idx, 32'h0);
      check(name, {24'h0, exp}, rd);
   endtask

   // Status byte as software should see it: control bits, overrun flag and head-of-buffer flags
   function automatic logic [7:0] stat(input logic [7:0] ctl, input logic fe, input logic ov,
                                       input logic n9);
      return (ctl & 8'hF0) | {5'h0, fe, ov, n9};
   endfunction

   initial begin
      nrst = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rd = $urandom(89);
      regs = '{`ASR_IDX_INT_CTRL, `ASR_IDX_PERIPH_FLAGS, `ASR_IDX_RX_STAT_CTRL, `ASR_IDX_TX_BUF,
               `ASR_IDX_RX_FIFO, `ASR_IDX_PERIPH_EN, `ASR_IDX_TX_STAT_CTRL, `ASR_IDX_BAUD_DIV,
               8'h40};
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      // Reset values, an unmapped index among them
      for (int i = 0; i < 9; i++) begin
         rdchk("reset", regs[i], regs[i] == `ASR_IDX_TX_STAT_CTRL ? 8'h02 : 8'h00);
      end
      wr(`ASR_IDX_PERIPH_FLAGS, 8'hFF);
      rdchk("flags_ro", `ASR_IDX_PERIPH_FLAGS, 8'hDF);
      wr(`ASR_IDX_PERIPH_FLAGS, 8'h00);
      wr(`ASR_IDX_RX_FIFO, 8'h5A);
      rdchk("fifo_ro", `ASR_IDX_RX_FIFO, 8'h00);
      wr(8'h40, 8'hFF);
      rdchk("unmapped", 8'h40, 8'h00);
      // Fast sampling, port on but reception still off
      wr(`ASR_IDX_BAUD_DIV, 8'h00);
      wr(`ASR_IDX_TX_STAT_CTRL, 8'h04);
      wr(`ASR_IDX_RX_STAT_CTRL, 8'h80);
      u_asr_tx_model.send({1'b0, 8'h96}, 1'b0, 1'b1);
      rdchk("no_enable", `ASR_IDX_PERIPH_FLAGS, 8'h00);
      // Synchronous mode selected: reception must stay off even with both enables
      wr(`ASR_IDX_TX_STAT_CTRL, 8'h14);
      wr(`ASR_IDX_RX_STAT_CTRL, 8'h90);
      u_asr_tx_model.send({1'b0, 8'h69}, 1'b0, 1'b1);
      rdchk("sync_off", `ASR_IDX_PERIPH_FLAGS, 8'h00);
      wr(`ASR_IDX_TX_STAT_CTRL, 8'h04);
      wr(`ASR_IDX_RX_STAT_CTRL, 8'h90);
      wr(`ASR_IDX_INT_CTRL, 8'hC0);
      wr(`ASR_IDX_PERIPH_EN, 8'h20);
      // Random words with all-zero and all-one corners
      for (int i = 0; i < 6; i++) begin
         b0 = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
         u_asr_tx_model.send({1'b0, b0}, 1'b0, 1'b1);
         rdchk("ready", `ASR_IDX_PERIPH_FLAGS, 8'h20);
         check("irq_on", 32'h1, {31'h0, rx_irq_r});
         wr(`ASR_IDX_PERIPH_EN, 8'h00);
         rdchk("status", `ASR_IDX_RX_STAT_CTRL, stat(8'h90, 1'b0, 1'b0, 1'b0));
         check("irq_off", 32'h0, {31'h0, rx_irq_r});
         wr(`ASR_IDX_PERIPH_EN, 8'h20);
         rdchk("data", `ASR_IDX_RX_FIFO, b0);
         rdchk("ready_clr", `ASR_IDX_PERIPH_FLAGS, 8'h00);
      end
      // Three words unread: two kept in order, third overruns
      for (int k = 0; k < 3; k++) begin
         b[k] = 8'($urandom);
         u_asr_tx_model.send({1'b0, b[k]}, 1'b0, 1'b1);
      end
      rdchk("overrun", `ASR_IDX_RX_STAT_CTRL, stat(8'h90, 1'b0, 1'b1, 1'b0));
      rdchk("fifo0", `ASR_IDX_RX_FIFO, b[0]);
      rdchk("fifo1", `ASR_IDX_RX_FIFO, b[1]);
      rdchk("empty", `ASR_IDX_PERIPH_FLAGS, 8'h00);
      u_asr_tx_model.send({1'b0, 8'hA5}, 1'b0, 1'b1);
      rdchk("blocked", `ASR_IDX_PERIPH_FLAGS, 8'h00);
      rdchk("ovr_hold", `ASR_IDX_RX_STAT_CTRL, stat(8'h90, 1'b0, 1'b1, 1'b0));
      wr(`ASR_IDX_RX_STAT_CTRL, 8'h80);
      wr(`ASR_IDX_RX_STAT_CTRL, 8'h90);
      rdchk("ovr_clr", `ASR_IDX_RX_STAT_CTRL, stat(8'h90, 1'b0, 1'b0, 1'b0));
      // Nine-bit words: framing error and ninth bit follow the buffer head
      wr(`ASR_IDX_RX_STAT_CTRL, 8'h80);
      wr(`ASR_IDX_RX_STAT_CTRL, 8'hD0);
      u_asr_tx_model.send(9'h1C3, 1'b1, 1'b0);
      u_asr_tx_model.send(9'h03C, 1'b1, 1'b1);
      rdchk("framing_error_n9", `ASR_IDX_RX_STAT_CTRL, stat(8'hD0, 1'b1, 1'b0, 1'b1));
      rdchk("word9a", `ASR_IDX_RX_FIFO, 8'hC3);
      rdchk("next_st", `ASR_IDX_RX_STAT_CTRL, stat(8'hD0, 1'b0, 1'b0, 1'b0));
      rdchk("word9b", `ASR_IDX_RX_FIFO, 8'h3C);
      // Slow sampling: four clocks per tick, sixty-four per bit
      wr(`ASR_IDX_RX_STAT_CTRL, 8'h90);
      wr(`ASR_IDX_TX_STAT_CTRL, 8'h00);
      u_asr_tx_model.bit_clks = 64;
      b0 = 8'($urandom);
      u_asr_tx_model.send({1'b0, b0}, 1'b0, 1'b1);
      rdchk("slow", `ASR_IDX_RX_FIFO, b0);
      give_verdict();
   end
endmodule

// >>> verif/asr_tx_model.sv
// Remote asynchronous transmitter that drives frames onto the receive line.
// Assumes the caller invokes send just after a clk_sys rising edge.
`timescale 1ns/1ns
module asr_tx_model (
   // Clock
   input wire logic clk_sys,
   // Serial line
   output logic rx_pin
);
   // Clocks per bit; the bench sets this to match the sample rate it programs
   int bit_clks = 16;

   // Line idles high between frames, as if pulled up
   initial rx_pin = 1'b1;

   // One start bit, data LSB first, optional ninth bit, one stop bit, then idle
   task automatic send(input logic [8:0] word, input logic nine, input logic stop_lvl);
      logic [10:0] frm;
      int nbits;
      frm = nine ? {stop_lvl, word, 1'b0} : {1'b1, stop_lvl, word[7:0], 1'b0};
      nbits = nine ? 11 : 10;
      for (int i = 0; i < nbits + 1; i++) begin
         @(posedge clk_sys);
         rx_pin <= (i < nbits) ? frm[i] : 1'b1;
         repeat (bit_clks - 1) @(posedge clk_sys);
      end
   endtask
endmodule
